// ==== rtl/spi_config_port.sv ====
// Purpose: Serial configuration port with bus fault flags, frame checking and sleep mode.
// Assumes: Host is the serial master; serial clock idles and select stays high between frames.
// Notes: Register images are frozen while select is low so the serial side reads stable words.
`timescale 1ns/10ps
`include "spi_cfg_params.svh"

// Notes on behaviour
// - Frame: 7-bit address, rw bit, data bytes
// - Valid frames are 16, 24 or 32 clocks
// - Burst bytes use incremented register address
// - First byte out is the global status
// - Serial input sampled on rising clock edge
// - Serial output changes on falling clock edge
// - Output released while select is high
// - Output driven while select is low
// - Global fault bit shown at select fall
// - Fault needs four long-dominant recessive edges
// - Recorded fault sets flag; write clears
// - Bits 5,4,3: shorted, high-bat, low-gnd
// - Bit 2 flags open bus
// - Bit 1 flags ground short
// - Bit 0 flags battery short
// - Enabling fail-safe in sleep keeps sleep
// - Writes commit only at select rise, exact or 31
// - Wrong clock count sets frame error
// - 31 clocks commit two bytes only
// - Global fault flag is bit 7 of 0x50
module spi_config_port
   import spi_cfg_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic sclk,
   input wire logic select_low,
   input wire logic serial_in_pin,
   output logic serial_out_pin,
   output logic serial_out_oe_n,
   input wire logic bus_dominant,
   input wire logic fault_lines_shorted,
   input wire logic fault_high_to_battery,
   input wire logic fault_low_to_ground,
   input wire logic fault_bus_open,
   input wire logic fault_ground_short,
   input wire logic fault_battery_short,
   input wire logic sleep_fault,
   input wire logic wake_req,
   output logic fault_irq,
   output logic in_sleep,
   output logic in_failsafe
);

   // ==========================================================
   // Link side: capture on rising serial clock
   logic active_q;
   logic frame_tog_q;
   logic [5:0] cnt_q;
   logic [6:0] addr_q;
   logic rw_q;
   logic [23:0] data_q;
   logic [4:0] data_pos;
   logic link_idle;

   // Select high clears the frame-active marker, so the next rising edge is bit 0
   assign link_idle = rst | select_low;
   assign data_pos = 5'(`CNT_LAST - cnt_q);

   always_ff @(posedge sclk or posedge link_idle) begin
      if (link_idle) begin
         active_q <= 1'b0;
      end else begin
         active_q <= 1'b1;
      end
   end

   // Count saturates past the longest frame, so an overlong frame stays illegal
   always_ff @(posedge sclk or posedge rst) begin
      if (rst) begin
         cnt_q <= `CNT_RST;
         frame_tog_q <= 1'b0;
      end else if (!select_low) begin
         cnt_q <= active_q ? ((cnt_q == `CNT_MAX) ? cnt_q : cnt_q + 6'h01) : 6'h01;
         frame_tog_q <= active_q ? frame_tog_q : ~frame_tog_q;
      end
   end

   logic [5:0] bit_idx;
   assign bit_idx = active_q ? cnt_q : `CNT_RST;

   // Partial bytes land in data_q but are never committed
   always_ff @(posedge sclk or posedge rst) begin
      if (rst) begin
         addr_q <= `ADDR_RST;
         rw_q <= 1'b0;
         data_q <= `DATA_RST;
      end else if (!select_low) begin
         if (bit_idx < `CNT_RW) begin
            addr_q <= {addr_q[5:0], serial_in_pin};
         end else if (bit_idx == `CNT_RW) begin
            rw_q <= serial_in_pin;
         end else if (bit_idx <= `CNT_LAST) begin
            data_q[data_pos] <= serial_in_pin;
         end
      end
   end

   // ==========================================================
   // Link side: output bit selection
   logic [7:0] shadow_status_q;
   logic [7:0] shadow_frame_q;
   logic [7:0] shadow_mode_q;
   logic [7:0] shadow_flags_q;
   logic [2:0] out_byte;
   logic [2:0] out_bitpos;
   logic [6:0] rd_addr;
   logic [7:0] rd_byte;
   logic [7:0] tx_byte;
   logic tx_bit;
   logic out_q;
   logic shown_q;

   assign out_byte = cnt_q[5:3];
   assign out_bitpos = 3'h7 - cnt_q[2:0];
   assign rd_addr = addr_q + {4'h0, out_byte} - `ADDR_ONE;
   // Unmapped addresses read as zero
   assign rd_byte = (rd_addr == `ADDR_GLOBAL) ? shadow_status_q :
                    (rd_addr == `ADDR_FRAME) ? shadow_frame_q :
                    (rd_addr == `ADDR_MODE) ? shadow_mode_q :
                    (rd_addr == `ADDR_FLAGS) ? shadow_flags_q : `BYTE_RST;
   assign tx_byte = (out_byte == 3'h0) ? shadow_status_q :
                    ((out_byte <= 3'h3) && (rw_q != `RW_WRITE)) ? rd_byte : `BYTE_RST;
   assign tx_bit = tx_byte[out_bitpos];

   // Cleared with select high, so every frame starts from the status bit
   always_ff @(negedge sclk or posedge link_idle) begin
      if (link_idle) begin
         out_q <= 1'b0;
         shown_q <= 1'b0;
      end else begin
         out_q <= tx_bit;
         shown_q <= 1'b1;
      end
   end

   // Before the first falling edge the pin shows the global fault flag straight away
   assign serial_out_pin = shown_q ? out_q : shadow_status_q[`GST_FAULT];
   assign serial_out_oe_n = select_low;

   // ==========================================================
   // Core side: synchronisers for pins and the frame toggle
   logic [10:0] sync1_q;
   logic [10:0] sync2_q;
   logic sel_prev_q;
   logic tog_seen_q;
   logic sel_s;
   logic tog_s;
   logic dom_s;
   logic sleep_s;
   logic wake_s;
   logic [5:0] fault_s;
   logic frame_end;

   // Select idles high and every other pin idles low, so reset makes no false edge
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sync1_q <= `SYNC_RST;
         sync2_q <= `SYNC_RST;
         sel_prev_q <= 1'b1;
         tog_seen_q <= 1'b0;
      end else begin
         sync1_q <= {wake_req, sleep_fault, bus_dominant, frame_tog_q, select_low, fault_lines_shorted,
                     fault_high_to_battery, fault_low_to_ground, fault_bus_open, fault_ground_short,
                     fault_battery_short};
         sync2_q <= sync1_q;
         sel_prev_q <= sel_s;
         tog_seen_q <= frame_end ? tog_s : tog_seen_q;
      end
   end

   assign wake_s = sync2_q[10];
   assign sleep_s = sync2_q[9];
   assign dom_s = sync2_q[8];
   assign tog_s = sync2_q[7];
   assign sel_s = sync2_q[6];
   assign fault_s = sync2_q[5:0];

   // ==========================================================
   // Core side: frame end check and commit
   logic had_clocks;
   logic [5:0] frame_len;
   logic len_ok;
   logic [1:0] n_bytes;
   logic do_write;

   // Link words are stable here: the serial clock is idle once select is high
   assign frame_end = sel_s & ~sel_prev_q;
   // The toggle tells a clockless frame from a stale count of the frame before
   assign had_clocks = (tog_s != tog_seen_q);
   assign frame_len = had_clocks ? cnt_q : `CNT_RST;
   assign len_ok = (frame_len == `LEN_ONE) || (frame_len == `LEN_TWO) || (frame_len == `LEN_THREE);
   // A 31-clock write, one clock short of 32, still commits its first two bytes
   assign n_bytes = (frame_len == `LEN_ONE) ? `BYTES_ONE :
                    (frame_len == `LEN_TWO) ? `BYTES_TWO :
                    (frame_len == `LEN_THREE) ? `BYTES_THREE :
                    (frame_len == `LEN_SHORT) ? `BYTES_TWO : `BYTES_ZERO;
   assign do_write = frame_end & (rw_q == `RW_WRITE);

   logic [5:0] flags_clr;
   logic frame_clr;
   logic mode_wr;
   logic mode_wdata;

   always_comb begin
      logic [6:0] wa;
      logic [7:0] wd;
      flags_clr = `FLAGS_RST;
      frame_clr = 1'b0;
      mode_wr = 1'b0;
      mode_wdata = 1'b0;
      wa = `ADDR_RST;
      wd = `BYTE_RST;
      for (int k = 0; k < 3; k++) begin
         if (do_write && (2'(k) < n_bytes)) begin
            wa = addr_q + 7'(k);
            wd = data_q[(2 - k) * 8 +: 8];
            if (wa == `ADDR_FLAGS) begin
               flags_clr = flags_clr | wd[5:0];
            end
            if (wa == `ADDR_FRAME) begin
               frame_clr = frame_clr | wd[`GST_FRAME];
            end
            if (wa == `ADDR_MODE) begin
               mode_wr = 1'b1;
               mode_wdata = wd[0];
            end
         end
      end
   end

   // ==========================================================
   // Core side: fault qualification and sticky flags
   logic [5:0] fault_hit;
   logic [5:0] flags_q;
   logic frame_err_q;
   logic failsafe_en_q;

   // Bit order: 5 shorted, 4 high-bat, 3 low-gnd, 2 open, 1 gnd, 0 bat
   genvar g;
   generate
      for (g = 0; g < 6; g++) begin : g_qual
         fault_qualifier u_qual (
            .clk(clk),
            .rst(rst),
            .fault_s(fault_s[g]),
            .dom_s(dom_s),
            .hit(fault_hit[g])
         );
      end
   endgenerate

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         flags_q <= `FLAGS_RST;
         frame_err_q <= 1'b0;
         failsafe_en_q <= 1'b0;
      end else begin
         // Set wins over a clear in the same cycle, so no fault is lost
         flags_q <= (flags_q & ~flags_clr) | fault_hit;
         frame_err_q <= (frame_err_q & ~frame_clr) | (frame_end & ~len_ok);
         failsafe_en_q <= mode_wr ? mode_wdata : failsafe_en_q;
      end
   end

   assign fault_irq = frame_err_q | (|flags_q);

   // ==========================================================
   // Core side: sleep and fail-safe mode
   mode_t mode_q;
   mode_t mode_d;
   logic sleep_prev_q;
   logic sleep_rise;

   assign sleep_rise = sleep_s & ~sleep_prev_q;

   always_comb begin
      mode_d = mode_q;
      unique case (mode_q)
         MODE_NORMAL: begin
            if (sleep_rise) begin
               mode_d = failsafe_en_q ? MODE_FAILSAFE : MODE_SLEEP;
            end
         end
         MODE_SLEEP: begin
            // Turning fail-safe on here has no effect until after wake and the next sleep fault
            if (wake_s) begin
               mode_d = MODE_NORMAL;
            end
         end
         MODE_FAILSAFE: begin
            if (wake_s) begin
               mode_d = MODE_NORMAL;
            end
         end
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mode_q <= MODE_NORMAL;
         sleep_prev_q <= 1'b0;
      end else begin
         mode_q <= mode_d;
         sleep_prev_q <= sleep_s;
      end
   end

   assign in_sleep = (mode_q == MODE_SLEEP);
   assign in_failsafe = (mode_q == MODE_FAILSAFE);

   // ==========================================================
   // Read images, frozen while a frame is in progress
   logic [7:0] status_now;
   logic freeze;

   assign status_now = {frame_err_q | (|flags_q), |flags_q, frame_err_q, 5'h00};
   // Images update only with select high, so multi-bit words never change under the link
   assign freeze = ~sel_s | frame_end;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         shadow_status_q <= `BYTE_RST;
         shadow_frame_q <= `BYTE_RST;
         shadow_mode_q <= `BYTE_RST;
         shadow_flags_q <= `BYTE_RST;
      end else if (!freeze) begin
         shadow_status_q <= status_now;
         shadow_frame_q <= {2'h0, frame_err_q, 5'h00};
         shadow_mode_q <= {4'h0, in_failsafe, in_sleep, 1'b0, failsafe_en_q};
         shadow_flags_q <= {2'h0, flags_q};
      end
   end

endmodule : spi_config_port

// ==== rtl/spi_cfg_params.svh ====
// Purpose: Named constants for the serial configuration port and bus fault flags.
// Assumes: Included by its bare name from the design files.
// Notes: Timing counts derive from the minimum dominant time and the core clock period.
`ifndef SPI_CFG_PARAMS_SVH
`define SPI_CFG_PARAMS_SVH

// ==========================================================
// Register map (7-bit addresses)
`define ADDR_GLOBAL 7'h50
`define ADDR_FRAME 7'h51
`define ADDR_MODE 7'h52
`define ADDR_FLAGS 7'h54
`define ADDR_ONE 7'h01

// ==========================================================
// Global status byte fields
`define GST_FAULT 7
`define GST_BUS 6
`define GST_FRAME 5

// ==========================================================
// Frame layout, counted in rising serial clock edges
`define RW_WRITE 1'b1
`define CNT_RW 6'h07
`define CNT_DATA0 6'h08
`define CNT_LAST 6'h1f
`define CNT_MAX 6'h21
`define LEN_ONE 6'h10
`define LEN_TWO 6'h18
`define LEN_THREE 6'h20
`define LEN_SHORT 6'h1f
`define BYTES_ZERO 2'h0
`define BYTES_ONE 2'h1
`define BYTES_TWO 2'h2
`define BYTES_THREE 2'h3

// ==========================================================
// Reset values
`define FLAGS_RST 6'h00
`define BYTE_RST 8'h00
`define ADDR_RST 7'h00
`define DATA_RST 24'h00_0000
`define CNT_RST 6'h00
`define SYNC_RST 11'h040

// ==========================================================
// Bus fault qualification
`define CLK_PERIOD_NS 8
`define DOM_MIN_NS 2000
`define DOM_MIN_CYC ((`DOM_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DOM_CNT_W 9
`define QUAL_EDGES 3'h4
`define QUAL_RST 3'h0

`endif

// ==== rtl/spi_cfg_pkg.sv ====
// Purpose: Types shared by the configuration port design.
// Assumes: Nothing beyond a SystemVerilog tool.
// Notes: Constants live in the params header.
package spi_cfg_pkg;

   // ==========================================================
   // Operating mode seen by the sleep and fail-safe logic
   typedef enum logic [1:0] {
      MODE_NORMAL,
      MODE_SLEEP,
      MODE_FAILSAFE
   } mode_t;

endpackage : spi_cfg_pkg

// ==== rtl/fault_qualifier.sv ====
// Purpose: Qualifies one raw bus fault level against dominant-to-recessive edges.
// Assumes: Inputs already synchronised to clk.
// Notes: A fault that drops out at any time restarts the edge count.
`timescale 1ns/10ps
`include "spi_cfg_params.svh"

module fault_qualifier (
   input wire logic clk,
   input wire logic rst,
   input wire logic fault_s,
   input wire logic dom_s,
   output logic hit
);

   logic dom_prev_q;
   logic [`DOM_CNT_W-1:0] dom_cnt_q;
   logic [`DOM_CNT_W-1:0] dom_cnt_d;
   logic [2:0] edge_cnt_q;
   logic [2:0] edge_cnt_d;
   logic long_dom;
   logic good_edge;

   // ==========================================================
   // Dominant length and qualified edge counting
   assign long_dom = (dom_cnt_q >= `DOM_CNT_W'(`DOM_MIN_CYC));
   assign good_edge = dom_prev_q & ~dom_s & long_dom & fault_s;
   assign hit = good_edge & (edge_cnt_q == (`QUAL_EDGES - 3'h1));
   assign dom_cnt_d = ~dom_s ? `DOM_CNT_W'(0) : (long_dom ? dom_cnt_q : dom_cnt_q + `DOM_CNT_W'(1));
   assign edge_cnt_d = (~fault_s | hit) ? `QUAL_RST : (good_edge ? edge_cnt_q + 3'h1 : edge_cnt_q);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dom_prev_q <= 1'b0;
         dom_cnt_q <= `DOM_CNT_W'(0);
         edge_cnt_q <= `QUAL_RST;
      end else begin
         dom_prev_q <= dom_s;
         dom_cnt_q <= dom_cnt_d;
         edge_cnt_q <= edge_cnt_d;
      end
   end

endmodule : fault_qualifier

// ==== bench/cfg_port_checker.sv ====
// Purpose: Port properties of the configuration port.
// Assumes: Fault inputs held steady for many cycles.
// Notes: Serial bit timing is judged by the bench.
`timescale 1ns/10ps
module cfg_port_checker (
   input wire logic clk,
   input wire logic rst,
   input wire logic select_low,
   input wire logic serial_out_pin,
   input wire logic serial_out_oe_n,
   input wire logic fault_lines_shorted,
   input wire logic fault_high_to_battery,
   input wire logic fault_low_to_ground,
   input wire logic fault_bus_open,
   input wire logic fault_ground_short,
   input wire logic fault_battery_short,
   input wire logic fault_irq,
   input wire logic in_sleep,
   input wire logic in_failsafe
);
   // ========
   // Helpers
   logic any_fault;
   logic [9:0] age_q;
   logic [9:0] age_d;
   assign any_fault = fault_lines_shorted | fault_high_to_battery | fault_low_to_ground
      | fault_bus_open | fault_ground_short | fault_battery_short;
   // Saturates so a long fault never wraps back below the bound
   assign age_d = !any_fault ? 10'h000 : (age_q == 10'h3ff) ? age_q : age_q + 10'h001;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         age_q <= 10'h000;
      end else begin
         age_q <= age_d;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // ========
   // Properties
   sequence s_calm_select;
      $stable(fault_irq)[*4] ##1 $fell(select_low);
   endsequence
   property p_release; select_low |-> serial_out_oe_n; endproperty
   property p_drive; !select_low |-> !serial_out_oe_n; endproperty
   property p_oe_edges; $changed(select_low) |-> $changed(serial_out_oe_n); endproperty
   property p_fault_shown; s_calm_select |-> serial_out_pin == fault_irq; endproperty
   // Frame errors rise just after deselect, so only long-idle rises are faults
   property p_no_early; $rose(fault_irq) && select_low && $past(select_low, 5) |-> age_q >= 10'h3e8; endproperty
   property p_sticky; fault_irq && !select_low |=> fault_irq; endproperty
   property p_sleep_holds; in_sleep |=> !in_failsafe; endproperty
   property p_one_mode; !(in_sleep && in_failsafe); endproperty
   a_release: assert property (p_release) else $error("output driven while deselected");
   a_drive: assert property (p_drive) else $error("output released while selected");
   a_oe_edges: assert property (p_oe_edges) else $error("enable missed a select edge");
   a_fault_shown: assert property (p_fault_shown) else $error("wrong fault level at select");
   a_no_early: assert property (p_no_early) else $error("fault recorded too early");
   a_sticky: assert property (p_sticky) else $error("flag lost during frame");
   a_sleep_holds: assert property (p_sleep_holds) else $error("left sleep for fail-safe");
   a_one_mode: assert property (p_one_mode) else $error("two modes at once");
endmodule : cfg_port_checker

// ==== bench/host_master.sv ====
// Purpose: Serial master standing in for the host processor.
// Assumes: Link clock idles low between frames.
// Notes: Link clock runs only inside a frame, 6 ns period.
`timescale 1ns/10ps
module host_master (
   input wire logic clk,
   input wire logic serial_out_pin,
   output logic sclk,
   output logic select_low,
   output logic serial_in_pin
);
   initial begin
      sclk = 1'b0;
      select_low = 1'b1;
      serial_in_pin = 1'b0;
   end
   // ========
   // One frame of n link clocks; rx fills from bit 31 down
   task automatic xfer(input int n, input logic [31:0] tx, output logic [31:0] rx, output logic first);
      rx = 32'h0000_0000;
      @(posedge clk);
      #1 select_low = 1'b0;
      #1 first = serial_out_pin;
      // Device freezes its images before the first edge
      repeat (4) @(posedge clk);
      #2;
      for (int i = 0; i < n; i++) begin
         serial_in_pin = tx[31 - i];
         #3 rx[31 - i] = serial_out_pin;
         sclk = 1'b1;
         #3 sclk = 1'b0;
      end
      #3 @(posedge clk);
      #1 select_low = 1'b1;
      // Released line must not keep the last bit
      serial_in_pin = ~serial_in_pin;
      repeat (8) @(posedge clk);
      #1;
   endtask : xfer
endmodule : host_master

// ==== bench/tb_top.sv ====
// Purpose: Self-checking bench for the configuration port.
// Assumes: Bus faults need 2 us dominant bits.
// Notes: Expected values come from the register layout only.
`timescale 1ns/10ps
module tb_top;
   import spi_cfg_pkg::*;
   logic clk, rst, bus_dominant, sleep_fault, wake_req, first;
   logic [5:0] flt;
   logic [31:0] rx;
   wire sclk, select_low, serial_in_pin, serial_out_pin, serial_out_oe_n, fault_irq, in_sleep, in_failsafe;
   int bad_count = 0;
   int n_tests = 0;
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   host_master i_host (.clk(clk), .serial_out_pin(serial_out_pin), .sclk(sclk),
      .select_low(select_low), .serial_in_pin(serial_in_pin));
   spi_config_port i_dut (.clk(clk), .rst(rst), .sclk(sclk), .select_low(select_low),
      .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin), .serial_out_oe_n(serial_out_oe_n),
      .bus_dominant(bus_dominant), .fault_lines_shorted(flt[5]), .fault_high_to_battery(flt[4]),
      .fault_low_to_ground(flt[3]), .fault_bus_open(flt[2]), .fault_ground_short(flt[1]),
      .fault_battery_short(flt[0]), .sleep_fault(sleep_fault), .wake_req(wake_req),
      .fault_irq(fault_irq), .in_sleep(in_sleep), .in_failsafe(in_failsafe));
   // ========
   // Shared tasks
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      i_host.xfer(16, {a, 1'b1, d, 16'h0000}, rx, first);
   endtask : wr
   task automatic rd(input logic [6:0] a, input int n);
      i_host.xfer(n, {a, 1'b0, 24'h00_0000}, rx, first);
   endtask : rd
   task automatic qualify(input logic [5:0] f, input int edges);
      flt = f;
      repeat (edges) begin
         bus_dominant = 1'b1;
         tick(260);
         bus_dominant = 1'b0;
         tick(20);
      end
      flt = 6'h00;
      tick(10);
   endtask : qualify
   // ========
   // Scenarios
   task automatic t_faults();
      for (int b = 0; b < 6; b++) begin
         qualify(6'h01 << b, 3);
         rd(7'h54, 16);
         check("early flag", rx[23:16], 8'h00);
         qualify(6'h01 << b, 4);
         check("irq", {7'h00, fault_irq}, 8'h01);
         rd(7'h52, 32);
         check("first bit", {7'h00, first}, 8'h01);
         check("status", rx[31:24], 8'hc0);
         check("flags", rx[7:0], 8'h01 << b);
         check("unmapped", rx[15:8], 8'h00);
         wr(7'h54, 8'h01 << b);
         rd(7'h54, 16);
         check("cleared", rx[23:16], 8'h00);
         check("first clear", {7'h00, first}, 8'h00);
      end
      $display("fault flags done");
   endtask : t_faults
   task automatic t_length();
      int lens [3] = '{0, 15, 23};
      foreach (lens[k]) begin
         i_host.xfer(lens[k], {7'h52, 1'b1, 8'h01, 16'h0000}, rx, first);
         rd(7'h51, 16);
         check("frame error", rx[23:16], 8'h20);
         check("error status", rx[31:24], 8'ha0);
         wr(7'h51, 8'h20);
         rd(7'h52, 16);
         check("no commit", rx[23:16], 8'h00);
         check("status clear", rx[31:24], 8'h00);
      end
      $display("frame length done");
   endtask : t_length
   task automatic t_sleep();
      sleep_fault = 1'b1;
      tick(6);
      sleep_fault = 1'b0;
      tick(4);
      wr(7'h52, 8'h01);
      check("stays asleep", {6'h00, in_failsafe, in_sleep}, 8'h01);
      rd(7'h52, 16);
      check("mode reg", rx[23:16], 8'h05);
      wake_req = 1'b1;
      tick(6);
      wake_req = 1'b0;
      tick(4);
      check("awake", {6'h00, in_failsafe, in_sleep}, 8'h00);
      sleep_fault = 1'b1;
      tick(6);
      sleep_fault = 1'b0;
      tick(4);
      check("to fail-safe", {6'h00, in_failsafe, in_sleep}, 8'h02);
      rd(7'h52, 16);
      check("fail-safe reg", rx[23:16], 8'h09);
      wake_req = 1'b1;
      tick(6);
      wake_req = 1'b0;
      tick(4);
      check("awake again", {6'h00, in_failsafe, in_sleep}, 8'h00);
      $display("sleep done");
   endtask : t_sleep
   task automatic t_burst();
      qualify(6'h01, 4);
      i_host.xfer(31, {7'h52, 1'b1, 8'h00, 8'hff, 8'hff}, rx, first);
      rd(7'h52, 32);
      check("two bytes", rx[23:16], 8'h00);
      check("third dropped", rx[7:0], 8'h01);
      rd(7'h51, 16);
      check("short error", rx[23:16], 8'h20);
      wr(7'h51, 8'h20);
      i_host.xfer(32, {7'h52, 1'b1, 8'h01, 8'h00, 8'h01}, rx, first);
      rd(7'h52, 32);
      check("burst mode", rx[23:16], 8'h01);
      check("burst clear", rx[7:0], 8'h00);
      check("irq low", {7'h00, fault_irq}, 8'h00);
      $display("burst done");
   endtask : t_burst
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : wrap_up
   initial begin
      rst = 1'b1;
      bus_dominant = 1'b0;
      flt = 6'h00;
      sleep_fault = 1'b0;
      wake_req = 1'b0;
      tick(8);
      rst = 1'b0;
      tick(6);
      check("idle enable", {7'h00, serial_out_oe_n}, 8'h01);
      t_faults();
      t_length();
      t_sleep();
      t_burst();
      wrap_up();
   end
endmodule : tb_top
bind spi_config_port cfg_port_checker i_chk (.clk, .rst, .select_low, .serial_out_pin, .serial_out_oe_n,
   .fault_lines_shorted, .fault_high_to_battery, .fault_low_to_ground, .fault_bus_open,
   .fault_ground_short, .fault_battery_short, .fault_irq, .in_sleep, .in_failsafe);
